// ---- design/status_comm_pkg.sv ----
/*
 * Constants, types and register layout of the status and communication
 * control register block. Assumes an AHB-Lite master with 32-bit data.
 */
package status_comm_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [31:0] STATUS_COMM_ADDR  = 32'h0000000C;
	localparam logic [31:0] LOCK_KEY_ADDR     = 32'h00000010;
	localparam logic [31:0] MAP_CHECKSUM_ADDR = 32'h00000014;
	localparam logic [23:0] STATUS_RESET      = 24'hA10001;
	localparam logic [23:0] STATUS_WR_MASK    = 24'hF7C800;
	localparam logic [7:0]  LOCK_KEY_RESET    = 8'h00;
	localparam logic [7:0]  UNLOCK_KEY        = 8'hA5;

	// ------------------------------------------------------------------
	// AHB-Lite encodings
	// ------------------------------------------------------------------
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic        HRESP_OKAY    = 1'h0;

	// ------------------------------------------------------------------
	// Serial address map shape
	// ------------------------------------------------------------------
	localparam int          ADDR_W        = 5;
	localparam logic [4:0]  MAP_LAST      = 5'h1F;
	localparam logic [4:0]  MAP_FIRST     = 5'h00;
	localparam logic [4:0]  TYPE_SPLIT    = 5'h08;
	localparam logic [4:0]  WRITE_FIRST   = 5'h08;
	localparam logic [4:0]  WRITE_LAST    = 5'h1F;

	// Checksum word lengths in bits
	localparam logic [5:0]  CRC_BITS_SHORT = 6'h10;
	localparam logic [5:0]  CRC_BITS_LONG  = 6'h20;
	localparam logic [15:0] ROUND_MAX      = 16'h7FFF;

	typedef enum logic [1:0] {
		STEP_HOLD,
		STEP_GROUP,
		STEP_TYPE,
		STEP_MAP
	} read_step_e;

	typedef enum logic [1:0] {
		FMT_16_ROUND,
		FMT_24,
		FMT_32_ZERO,
		FMT_32_SIGN
	} data_fmt_e;

	// Layout of the 24-bit register, bit 23 first
	typedef struct packed {
		read_step_e read_step;
		logic       write_inc;
		logic       idle_level;
		logic       unused19;
		logic       crc_wide;
		data_fmt_e  data_fmt;
		logic       link_crc;
		logic       alert_en;
		logic [1:0] reserved;
		logic       mdat_en;
		logic [9:0] unused;
		logic       pending;
	} status_cfg_s;

	// One tri-state pin that can drive high or low: level and enable
	typedef struct packed {
		logic level;
		logic oe;
	} pin_s;

endpackage : status_comm_pkg

// ---- design/addr_step.sv ----
/*
 * Next serial address pointer for read and write sequences.
 * Assumes the caller registers the result.
 */
`timescale 1ns/10ps
`default_nettype none
module addr_step
	import status_comm_pkg::*;
(
	input  wire logic [4:0] cur,
	input  wire read_step_e read_step,
	input  wire logic       write_inc,
	input  wire logic       is_write,
	output logic [4:0]      next
);
	// Wrap points per mode
	always_comb begin
		next = cur;
		if (is_write) begin
			if (write_inc)
				next = (cur == WRITE_LAST) ? WRITE_FIRST : 5'(cur + 5'h01);
		end else begin
			case (read_step)
				STEP_MAP:   next = (cur == MAP_LAST) ? MAP_FIRST : 5'(cur + 5'h01);
				STEP_TYPE: begin
					if (cur < TYPE_SPLIT)
						next = (cur == 5'(TYPE_SPLIT - 5'h01)) ? MAP_FIRST : 5'(cur + 5'h01);
					else
						next = (cur == MAP_LAST) ? TYPE_SPLIT : 5'(cur + 5'h01);
				end
				STEP_GROUP: next = {cur[4:2], 2'(cur[1:0] + 2'h1)};
				default:    next = cur;
			endcase
		end
	end
endmodule : addr_step
`default_nettype wire

// ---- design/result_format.sv ----
/*
 * Formats a 24-bit conversion result to the chosen word width.
 * Assumes the caller registers the word.
 */
`timescale 1ns/10ps
`default_nettype none
module result_format
	import status_comm_pkg::*;
(
	input  wire logic [23:0] sample,
	input  wire data_fmt_e   fmt,
	output logic [31:0]      word
);
	logic [15:0] rounded;

	// Rounding saturates so a full-scale positive value cannot wrap
	always_comb begin
		rounded = sample[23:8];
		if (sample[7] && sample[23:8] != ROUND_MAX)
			rounded = 16'(sample[23:8] + 16'h0001);
		case (fmt)
			FMT_16_ROUND: word = {16'h0000, rounded};
			FMT_24:       word = {8'h00, sample};
			FMT_32_ZERO:  word = {sample, 8'h00};
			default:      word = {{8{sample[23]}}, sample};
		endcase
	end
endmodule : result_format
`default_nettype wire

// ---- design/status_comm_control_register.sv ----
/*
 * Status and communication control register with its AHB-Lite slave,
 * serial address pointer, ready pin, result formatting and alert.
 * Assumes all inputs synchronous to sys_clk, single word transfers.
 */
`timescale 1ns/10ps
`default_nettype none
module status_comm_control_register
	import status_comm_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        new_result,
	input  wire logic [23:0] result_sample,
	input  wire logic        map_check_fail,
	input  wire logic [15:0] config_map_checksum,
	input  wire logic        modulator_bit_in,
	input  wire logic        ser_addr_load,
	input  wire logic [4:0]  ser_addr_value,
	input  wire logic        ser_addr_step,
	input  wire logic        ser_is_write,
	output logic [4:0]       ser_addr,
	output logic             data_ready_pin_out,
	output logic             data_ready_pin_oe,
	output logic             modulator_bitstream_out,
	output logic [31:0]      formatted_word,
	output logic             link_checksum_enable,
	output logic [5:0]       checksum_word_bits,
	output logic             alert_active
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	status_cfg_s cfg;
	status_cfg_s next_cfg;
	logic [7:0]  lock_key;
	logic [7:0]  next_lock_key;
	logic        dp_valid;
	logic        next_dp_valid;
	logic        dp_write;
	logic        next_dp_write;
	logic [31:0] dp_addr;
	logic [31:0] next_dp_addr;
	logic [31:0] next_hrdata;
	logic        alert;
	logic        next_alert;
	pin_s        pin;
	pin_s        next_pin;
	logic [4:0]  next_ser_addr;
	logic [4:0]  stepped_addr;
	logic [31:0] fmt_word;
	logic [31:0] next_formatted_word;
	logic        next_mdat;
	logic [5:0]  next_crc_bits;
	logic        accept;
	logic        read_status;

	// hsize is not decoded: only whole words are ever issued
	assign accept      = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign read_status = accept && !hwrite && (haddr == STATUS_COMM_ADDR);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	addr_step u_addr_step (
		.cur       (ser_addr),
		.read_step (cfg.read_step),
		.write_inc (cfg.write_inc),
		.is_write  (ser_is_write),
		.next      (stepped_addr)
	);

	result_format u_result_format (
		.sample (result_sample),
		.fmt    (cfg.data_fmt),
		.word   (fmt_word)
	);

	// ------------------------------------------------------------------
	// Bus slave: address phase capture, read data, write data phase
	// ------------------------------------------------------------------
	// Read data is prepared in the address phase so there are no waits
	always_comb begin
		next_dp_valid = accept;
		next_dp_write = accept && hwrite;
		next_dp_addr  = accept ? haddr : dp_addr;
		next_hrdata   = hrdata;
		if (accept && !hwrite) begin
			if (haddr == STATUS_COMM_ADDR)
				next_hrdata = {8'h00, cfg};
			else if (haddr == LOCK_KEY_ADDR)
				next_hrdata = {24'h000000, lock_key};
			else if (haddr == MAP_CHECKSUM_ADDR)
				next_hrdata = {16'h0000, config_map_checksum};
			else
				next_hrdata = 32'h00000000;
		end
	end

	// Register fields and key
	always_comb begin
		next_cfg      = cfg;
		next_lock_key = lock_key;
		if (dp_valid && dp_write) begin
			if (dp_addr == STATUS_COMM_ADDR)
				// Reserved, unimplemented and flag bits keep their value
				next_cfg = status_cfg_s'((hwdata[23:0] & STATUS_WR_MASK)
					| (cfg & ~STATUS_WR_MASK));
			else if (dp_addr == LOCK_KEY_ADDR)
				next_lock_key = hwdata[7:0];
		end
		// A fresh result beats the read that sets the flag back
		if (new_result)
			next_cfg.pending = 1'b0;
		else if (read_status)
			next_cfg.pending = 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cfg       <= status_cfg_s'(STATUS_RESET);
			lock_key  <= LOCK_KEY_RESET;
			dp_valid  <= 1'b0;
			dp_write  <= 1'b0;
			dp_addr   <= 32'h00000000;
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
		end else begin
			cfg       <= next_cfg;
			lock_key  <= next_lock_key;
			dp_valid  <= next_dp_valid;
			dp_write  <= next_dp_write;
			dp_addr   <= next_dp_addr;
			hrdata    <= next_hrdata;
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
		end
	end

	// ------------------------------------------------------------------
	// Configuration map checksum alert
	// ------------------------------------------------------------------
	// A fault in the same cycle as the unlock still raises the alert
	always_comb begin
		next_alert = alert;
		if (map_check_fail && cfg.alert_en)
			next_alert = 1'b1;
		else if (lock_key == UNLOCK_KEY)
			next_alert = 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (srst)
			alert <= 1'b0;
		else
			alert <= next_alert;
	end

	// ------------------------------------------------------------------
	// Ready pin
	// ------------------------------------------------------------------
	always_comb begin
		next_pin.level = 1'b0;
		next_pin.oe    = 1'b1;
		if (alert) begin
			next_pin.level = 1'b0;
			next_pin.oe    = 1'b1;
		end else if (!cfg.pending) begin
			next_pin.level = 1'b0;
			next_pin.oe    = 1'b1;
		end else begin
			next_pin.level = cfg.idle_level;
			next_pin.oe    = cfg.idle_level;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst)
			pin <= '0;
		else
			pin <= next_pin;
	end

	assign data_ready_pin_out = pin.level;
	assign data_ready_pin_oe  = pin.oe;

	// ------------------------------------------------------------------
	// Serial address pointer
	// ------------------------------------------------------------------
	// Load has priority so a new command always starts where asked
	always_comb begin
		next_ser_addr = ser_addr;
		if (ser_addr_load)
			next_ser_addr = ser_addr_value;
		else if (ser_addr_step)
			next_ser_addr = stepped_addr;
	end

	always_ff @(posedge sys_clk) begin
		if (srst)
			ser_addr <= MAP_FIRST;
		else
			ser_addr <= next_ser_addr;
	end

	// ------------------------------------------------------------------
	// Link side settings and data path outputs
	// ------------------------------------------------------------------
	always_comb begin
		next_formatted_word = new_result ? fmt_word : formatted_word;
		next_mdat           = cfg.mdat_en && modulator_bit_in;
		next_crc_bits       = cfg.crc_wide ? CRC_BITS_LONG : CRC_BITS_SHORT;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			formatted_word          <= 32'h00000000;
			modulator_bitstream_out <= 1'b0;
			checksum_word_bits      <= CRC_BITS_SHORT;
			link_checksum_enable    <= 1'b0;
			alert_active            <= 1'b0;
		end else begin
			formatted_word          <= next_formatted_word;
			modulator_bitstream_out <= next_mdat;
			checksum_word_bits      <= next_crc_bits;
			link_checksum_enable    <= cfg.link_crc;
			alert_active            <= alert;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence fault_armed;
		map_check_fail && cfg.alert_en;
	endsequence

	sequence pin_pulled_low;
		data_ready_pin_oe && !data_ready_pin_out;
	endsequence

	ptr_read_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
		ser_addr_step && !ser_addr_load && !ser_is_write && cfg.read_step == STEP_HOLD
		|=> ser_addr == $past(ser_addr))
		else $error("read pointer moved in hold mode");

	ptr_map_wrap_a: assert property (@(posedge sys_clk) disable iff (srst)
		ser_addr_step && !ser_addr_load && !ser_is_write && cfg.read_step == STEP_MAP
		&& ser_addr == MAP_LAST |=> ser_addr == MAP_FIRST)
		else $error("read pointer did not wrap over the map");

	ptr_write_wrap_a: assert property (@(posedge sys_clk) disable iff (srst)
		ser_addr_step && !ser_addr_load && ser_is_write && cfg.write_inc
		&& ser_addr == WRITE_LAST |=> ser_addr == WRITE_FIRST)
		else $error("write pointer did not wrap");

	pin_idle_hiz_a: assert property (@(posedge sys_clk) disable iff (srst)
		!alert && cfg.pending && !cfg.idle_level |=> !data_ready_pin_oe)
		else $error("ready pin driven while idle release selected");

	crc_width_a: assert property (@(posedge sys_clk) disable iff (srst)
		##1 checksum_word_bits == ($past(cfg.crc_wide) ? CRC_BITS_LONG : CRC_BITS_SHORT))
		else $error("checksum word length mismatch");

	fmt_sign_ext_a: assert property (@(posedge sys_clk) disable iff (srst)
		new_result && cfg.data_fmt == FMT_32_SIGN
		|=> formatted_word == {{8{$past(result_sample[23])}}, $past(result_sample)})
		else $error("sign extended word wrong");

	link_crc_a: assert property (@(posedge sys_clk) disable iff (srst)
		##1 link_checksum_enable == $past(cfg.link_crc))
		else $error("link checksum enable does not follow register");

	alert_pull_a: assert property (@(posedge sys_clk) disable iff (srst)
		fault_armed |-> ##2 pin_pulled_low)
		else $error("alert did not pull ready pin low");

	alert_release_a: assert property (@(posedge sys_clk) disable iff (srst)
		alert && lock_key == UNLOCK_KEY && !map_check_fail |=> !alert)
		else $error("alert not released by unlock key");

	alert_off_a: assert property (@(posedge sys_clk) disable iff (srst)
		!cfg.alert_en && !alert |=> !alert)
		else $error("alert raised while disabled");

	mdat_off_a: assert property (@(posedge sys_clk) disable iff (srst)
		!cfg.mdat_en |=> !modulator_bitstream_out)
		else $error("bitstream driven while disabled");

	unimpl_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
		dp_valid && !dp_write && dp_addr == STATUS_COMM_ADDR
		|-> (hrdata & 32'h000807FE) == 32'h00000000)
		else $error("unimplemented bits read nonzero");

	flag_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
		new_result |=> !cfg.pending)
		else $error("flag not cleared on new result");

	flag_read_set_a: assert property (@(posedge sys_clk) disable iff (srst)
		read_status && !new_result |=> cfg.pending)
		else $error("flag not set back by status read");

	flag_no_write_a: assert property (@(posedge sys_clk) disable iff (srst)
		dp_valid && dp_write && !new_result && !read_status
		|=> cfg.pending == $past(cfg.pending))
		else $error("write changed the data ready flag");

	// Only a new result or a status read may move the flag
	flag_result_keep_a: assert property (@(posedge sys_clk) disable iff (srst)
		!new_result && !read_status |=> cfg.pending == $past(cfg.pending))
		else $error("flag moved without result or status read");

	// Idle drive high when selected and no alert stands
	pin_idle_high_a: assert property (@(posedge sys_clk) disable iff (srst)
		!alert && cfg.pending && cfg.idle_level |=> data_ready_pin_oe && data_ready_pin_out)
		else $error("ready pin not driven high while idle");

	// Fresh data pulls the pin low one cycle after the flag drops
	pin_ready_low_a: assert property (@(posedge sys_clk) disable iff (srst)
		!alert && !cfg.pending |=> pin_pulled_low)
		else $error("ready pin not low with data ready");

	fmt_plain24_a: assert property (@(posedge sys_clk) disable iff (srst)
		new_result && cfg.data_fmt == FMT_24
		|=> formatted_word == {8'h00, $past(result_sample)})
		else $error("plain 24-bit word wrong");

	// Enabled output follows the modulator bit with one register of delay
	mdat_follow_a: assert property (@(posedge sys_clk) disable iff (srst)
		cfg.mdat_en |=> modulator_bitstream_out == $past(modulator_bit_in))
		else $error("bitstream does not follow modulator bit");

endmodule : status_comm_control_register
`default_nettype wire

// ---- verif/conv_side_model.sv ----
/*
 * Behavioural model of the converter side and of the ready pin wire.
 * Assumes the bench requests a result with a one-cycle fire pulse.
 */
`timescale 1ns/10ps
`default_nettype none
module conv_side_model (
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic        fire,
	input  wire logic [23:0] sample,
	input  wire logic        pin_out,
	input  wire logic        pin_oe,
	output logic             new_result,
	output logic [23:0]      result_sample,
	output logic             pin_level
);
	logic last_level;

	// ----------------------------------------------------------------
	// Result delivery
	// ----------------------------------------------------------------
	// One-cycle pulse, sample qualified by it
	always_ff @(posedge sys_clk) begin
		new_result    <= fire & ~srst;
		result_sample <= sample;
	end

	// ----------------------------------------------------------------
	// Ready pin wire
	// ----------------------------------------------------------------
	// No pull on the wire: a released pin shows the inverse of its last level
	always_ff @(posedge sys_clk) begin
		if (pin_oe) begin
			last_level <= pin_out;
		end
	end
	assign pin_level = pin_oe ? pin_out : ~last_level;
endmodule : conv_side_model
`default_nettype wire

// ---- verif/status_comm_control_register_tb.sv ----
/*
 * Self-checking bench of the status and communication register block.
 * Assumes a single AHB-Lite master with zero-wait slave and one clock.
 */
`timescale 1ns/10ps
`default_nettype none
module status_comm_control_register_tb;
	import status_comm_pkg::*;

	logic        sys_clk, srst, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, formatted_word;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        new_result, map_check_fail, modulator_bit_in, fire;
	logic        ser_addr_load, ser_addr_step, ser_is_write, pin_level;
	logic [23:0] result_sample, sample;
	logic [4:0]  ser_addr_value, ser_addr;
	logic        pin_out, pin_oe, mod_out, link_en, alert_active;
	logic [5:0]  checksum_word_bits;
	logic [15:0] map_sum;
	int          failures, samples_checked, cycles;

	// ----------------------------------------------------------------
	// Clock, design and partner
	// ----------------------------------------------------------------
	always #12.5 sys_clk = ~sys_clk;
	assign hready = hreadyout;

	status_comm_control_register i_dut (.sys_clk(sys_clk), .srst(srst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.new_result(new_result), .result_sample(result_sample),
		.map_check_fail(map_check_fail), .config_map_checksum(map_sum),
		.modulator_bit_in(modulator_bit_in), .ser_addr_load(ser_addr_load),
		.ser_addr_value(ser_addr_value), .ser_addr_step(ser_addr_step),
		.ser_is_write(ser_is_write), .ser_addr(ser_addr), .data_ready_pin_out(pin_out),
		.data_ready_pin_oe(pin_oe), .modulator_bitstream_out(mod_out),
		.formatted_word(formatted_word), .link_checksum_enable(link_en),
		.checksum_word_bits(checksum_word_bits), .alert_active(alert_active));

	conv_side_model i_conv (.sys_clk(sys_clk), .srst(srst), .fire(fire), .sample(sample),
		.pin_out(pin_out), .pin_oe(pin_oe), .new_result(new_result),
		.result_sample(result_sample), .pin_level(pin_level));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk

	// One single AHB transfer; waits on hready with a bound
	task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge sys_clk);
		hsel   <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr  <= a;
		hwrite <= w;
		@(posedge sys_clk);
		while (hready !== 1'b1 && n < 50) begin n++; @(posedge sys_clk); end
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge sys_clk);
		while (hready !== 1'b1 && n < 50) begin n++; @(posedge sys_clk); end
		r = hrdata;
		if (n == 50) chk(32'h0, 32'h1);
	endtask : ahb

	task automatic wr(input logic [31:0] a, d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask : wr

	task automatic rd_chk(input logic [31:0] a, e);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0, r);
		chk(r, e);
		chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
	endtask : rd_chk

	// Register word with reserved bits kept at zero
	function automatic logic [31:0] cfg(input logic [1:0] rs, input logic wi, il, cw,
		input logic [1:0] f, input logic lc, ae, md);
		return {8'h00, rs, wi, il, 1'b0, cw, f, lc, ae, 2'b00, md, 10'h000, 1'b0};
	endfunction : cfg

	// Let registered outputs land; not a protocol wait
	task automatic settle();
		repeat (3) @(posedge sys_clk);
		#1;
	endtask : settle

	task automatic pulse_result(input logic [23:0] s);
		@(posedge sys_clk);
		fire   <= 1'b1;
		sample <= s;
		@(posedge sys_clk);
		fire   <= 1'b0;
		settle();
	endtask : pulse_result

	task automatic pulse_fail();
		@(posedge sys_clk);
		map_check_fail <= 1'b1;
		@(posedge sys_clk);
		map_check_fail <= 1'b0;
		settle();
	endtask : pulse_fail

	task automatic ptr(input logic [1:0] rs, input logic wi, w, input logic [4:0] st, e);
		wr(STATUS_COMM_ADDR, cfg(rs, wi, 1'b0, 1'b0, 2'h1, 1'b0, 1'b0, 1'b0));
		@(posedge sys_clk);
		ser_addr_load  <= 1'b1;
		ser_addr_value <= st;
		@(posedge sys_clk);
		ser_addr_load <= 1'b0;
		ser_addr_step <= 1'b1;
		ser_is_write  <= w;
		@(posedge sys_clk);
		ser_addr_step <= 1'b0;
		settle();
		chk({27'h0, ser_addr}, {27'h0, e});
	endtask : ptr

	task automatic complete_run();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run

	// Hang guard, far beyond the few hundred cycles of the sequence
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			$display("[ERR] %0t timeout", $time);
			failures++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] fx [4];
		fx = '{32'h00001235, 32'h0012348A, 32'h12348A00, 32'hFFC00001};
		sys_clk = 0; srst = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
		hsize = 3'h2; hwdata = 0; fire = 0; sample = 0; map_check_fail = 0;
		modulator_bit_in = 1; ser_addr_load = 0; ser_addr_value = 0;
		ser_addr_step = 0; ser_is_write = 0; failures = 0; samples_checked = 0; cycles = 0;
		map_sum = 16'hBEEF;
		repeat (12) @(posedge sys_clk);
		srst <= 1'b0;
		rd_chk(STATUS_COMM_ADDR, 32'h00A10001);
		settle();
		chk({31'h0, pin_oe}, 32'h0);
		wr(STATUS_COMM_ADDR, 32'hFFFFCFFF);
		rd_chk(STATUS_COMM_ADDR, 32'h00F7C801);
		wr(STATUS_COMM_ADDR, 32'h0);
		rd_chk(STATUS_COMM_ADDR, 32'h00000001);
		wr(32'h20, 32'h5A5A5A5A);
		rd_chk(32'h20, 32'h0);
		rd_chk(LOCK_KEY_ADDR, 32'h0);
		rd_chk(MAP_CHECKSUM_ADDR, 32'h0000BEEF);
		// Every result format, then flag life cycle
		for (int f = 0; f < 4; f++) begin
			wr(STATUS_COMM_ADDR, cfg(2'h2, 1'b1, 1'b0, 1'b0, f[1:0], 1'b0, 1'b0, 1'b0));
			pulse_result(f == 3 ? 24'hC00001 : 24'h12348A);
			chk(formatted_word, fx[f]);
			chk({30'h0, pin_oe, pin_level}, 32'h2);
			rd_chk(MAP_CHECKSUM_ADDR, 32'h0000BEEF);
			rd_chk(STATUS_COMM_ADDR, cfg(2'h2, 1'b1, 1'b0, 1'b0, f[1:0], 1'b0, 1'b0, 1'b0));
			rd_chk(STATUS_COMM_ADDR, cfg(2'h2, 1'b1, 1'b0, 1'b0, f[1:0], 1'b0, 1'b0, 1'b0) | 1);
			settle();
			chk({31'h0, pin_oe}, 32'h0);
		end
		// Checksum width, link checksum, bitstream, idle-high pin
		for (int i = 0; i < 2; i++) begin
			wr(STATUS_COMM_ADDR, cfg(2'h2, 1'b1, 1'b1, i[0], 2'h1, i[0], 1'b0, i[0]));
			settle();
			chk({26'h0, checksum_word_bits}, i ? 32'd32 : 32'd16);
			chk({31'h0, link_en}, i);
			chk({31'h0, mod_out}, i);
			chk({30'h0, pin_oe, pin_level}, 32'h3);
		end
		@(posedge sys_clk);
		modulator_bit_in <= 1'b0;
		settle();
		chk({31'h0, mod_out}, 32'h0);
		// Map fault with alert off, then on, then unlock
		wr(STATUS_COMM_ADDR, cfg(2'h2, 1'b1, 1'b1, 1'b0, 2'h1, 1'b0, 1'b0, 1'b0));
		pulse_fail();
		chk({31'h0, alert_active}, 32'h0);
		@(posedge sys_clk);
		map_sum <= 16'h4321;
		rd_chk(MAP_CHECKSUM_ADDR, 32'h00004321);
		wr(STATUS_COMM_ADDR, cfg(2'h2, 1'b1, 1'b1, 1'b0, 2'h1, 1'b0, 1'b1, 1'b0));
		pulse_fail();
		settle();
		chk({30'h0, alert_active, pin_level}, 32'h2);
		wr(LOCK_KEY_ADDR, {24'h0, UNLOCK_KEY});
		settle();
		chk({30'h0, alert_active, pin_level}, 32'h1);
		// Pointer stepping in every read mode and both write modes
		ptr(2'h3, 1'b1, 1'b0, 5'h1F, 5'h00);
		ptr(2'h2, 1'b1, 1'b0, 5'h07, 5'h00);
		ptr(2'h2, 1'b1, 1'b0, 5'h1F, 5'h08);
		ptr(2'h1, 1'b1, 1'b0, 5'h0B, 5'h08);
		ptr(2'h1, 1'b1, 1'b0, 5'h09, 5'h0A);
		ptr(2'h0, 1'b1, 1'b0, 5'h05, 5'h05);
		ptr(2'h2, 1'b1, 1'b1, 5'h1F, 5'h08);
		ptr(2'h2, 1'b1, 1'b1, 5'h0C, 5'h0D);
		ptr(2'h2, 1'b0, 1'b1, 5'h0C, 5'h0C);
		complete_run();
	end
endmodule : status_comm_control_register_tb
`default_nettype wire
